// ===== rtl/ccb_engine.sv
// Byte-serial CRC engine top: input register, result register, two-cycle step
// Timing: a byte write is taken at one edge and its step lands at the next,
// so the result trails the write by two cycles. Bytes may come every cycle;
// each step reads the remainder that the step before it has just left.
// A seed write in the cycle in which a step lands wins, and that step is lost,
// so software has to let the last step finish before it seeds again.
// In reflected order the held remainder is kept reflected and is turned back
// before each step; the ordering is taken per byte, so changing it inside one
// calculation gives a value that matches neither ordering.
// The whole byte is divided in one cycle: eight shifts deep, fixed latency.
`timescale 1ns/10ps
`default_nettype none
module ccb_engine (
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire logic seed_wr_i,
	input wire logic [15:0] seed_data_i,
	input wire logic byte_wr_i,
	input wire logic [7:0] byte_data_i,
	input wire ccb_pkg::ccb_poly_type poly_sel_i,
	input wire logic lsb_first_i,
	output logic [15:0] result_o,
	output logic [7:0] byte_reg_o,
	output logic busy_o
);
	import ccb_pkg::*;

	// Captured byte and mode, step-pending flag, held remainder
	ccb_req_type in_reg;
	ccb_req_type in_next;
	logic pend_reg;
	logic pend_next;
	logic [15:0] result_reg;
	logic [15:0] result_next;
	logic [15:0] step_rem;

	// The divider itself; it reads the captured byte and the held remainder
	// Eight shifts in one cycle make a deep path but keep the latency fixed
	ccb_step u_step (
		.req_i(in_reg),
		.rem_i(result_reg),
		.rem_o(step_rem)
	);

	// First cycle: the byte and its mode are captured, so a mode change
	// later cannot disturb a step already under way
	always_comb begin
		in_next = in_reg;
		pend_next = byte_wr_i;
		if (byte_wr_i) begin
			in_next.data = byte_data_i;
			in_next.poly = poly_sel_i;
			in_next.lsb_first = lsb_first_i;
		end
	end

	// Second cycle: remainder lands; a seed write in the same cycle wins
	always_comb begin
		result_next = result_reg;
		if (seed_wr_i) begin
			result_next = seed_data_i;
		end else if (pend_reg) begin
			result_next = step_rem;
		end
	end

	// State registers
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			in_reg <= '{poly: CCB_POLY_SEL_CRC16, lsb_first: 1'b0, data: CCB_BYTE_RST};
			pend_reg <= 1'b0;
			result_reg <= CCB_RESULT_RST;
		end else begin
			in_reg <= in_next;
			pend_reg <= pend_next;
			result_reg <= result_next;
		end
	end

	// Outputs come straight from the registers, no logic after the flops
	assign result_o = result_reg;
	assign byte_reg_o = in_reg.data;
	assign busy_o = pend_reg;

	// Checks; all in the core clock domain and quiet while reset is low
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);

	// A byte taken with no seed write over it, then its step in flight
	sequence s_byte_taken;
		byte_wr_i && !seed_wr_i ##1 busy_o && !seed_wr_i;
	endsequence

	// The first byte of a calculation, 80h on a zero remainder
	sequence s_first_80;
		busy_o && !seed_wr_i && in_reg.data == 8'h80 && result_reg == 16'h0000;
	endsequence

	// A single byte write with nothing behind it
	sequence s_lone_byte;
		byte_wr_i ##1 !byte_wr_i;
	endsequence

	// Whatever the divider computed in the step cycle is what lands;
	// catches a landing one cycle early or late against the divider
	property p_step_lands;
		s_byte_taken |=> result_o == $past(step_rem);
	endproperty
	a_step_lands: assert property (p_step_lands) else $error("result not updated after step");

	// Busy rises after the write and follows the write one cycle on
	property p_latency;
		byte_wr_i |=> busy_o ##1 (busy_o == $past(byte_wr_i));
	endproperty
	a_latency: assert property (p_latency) else $error("step latency wrong");

	// Known single-byte remainders in three of the four modes, all but reflected CRC16; these hold whatever the
	// divider code looks like, so a wrong polynomial or ordering shows here
	property p_crc16;
		(s_first_80 and (in_reg.poly == CCB_POLY_SEL_CRC16 && !in_reg.lsb_first)) |=>
			result_o == 16'h8303;
	endproperty
	a_crc16: assert property (p_crc16) else $error("crc16 of 80h wrong");

	// Same byte under the alternative polynomial, natural order
	property p_ccitt;
		(s_first_80 and (in_reg.poly == CCB_POLY_SEL_CCITT && !in_reg.lsb_first)) |=>
			result_o == 16'h9188;
	endproperty
	a_ccitt: assert property (p_ccitt) else $error("ccitt of 80h wrong");

	// Reflected byte 01h gives the reflected remainder of 80h
	property p_lsb;
		busy_o && !seed_wr_i && in_reg.data == 8'h01 && result_reg == 16'h0000 &&
			in_reg.poly == CCB_POLY_SEL_CCITT && in_reg.lsb_first |=> result_o == 16'h1189;
	endproperty
	a_lsb: assert property (p_lsb) else $error("lsb-first result wrong");

	// Second byte on a held remainder, the remainder taken with 8 zero bits
	property p_chain;
		busy_o && !seed_wr_i && in_reg.data == 8'hC4 && result_reg == 16'h8303 &&
			in_reg.poly == CCB_POLY_SEL_CRC16 && !in_reg.lsb_first |=> result_o == 16'h0292;
	endproperty
	a_chain: assert property (p_chain) else $error("chained remainder wrong");

	// Second reflected byte: the held reflected remainder is turned back first
	property p_lsb_chain;
		busy_o && !seed_wr_i && in_reg.data == 8'h23 && result_reg == 16'h1189 &&
			in_reg.poly == CCB_POLY_SEL_CCITT && in_reg.lsb_first |=> result_o == 16'h0A41;
	endproperty
	a_lsb_chain: assert property (p_lsb_chain) else $error("reflected chain wrong");

	// Without a step or a seed the result register keeps its value,
	// so software may read it any number of times
	property p_hold;
		!busy_o && !seed_wr_i |=> $stable(result_o);
	endproperty
	a_hold: assert property (p_hold) else $error("result changed without cause");

	// A seed write replaces the result whole,
	// even over a step that lands in the same cycle
	property p_seed;
		seed_wr_i |=> result_o == $past(seed_data_i);
	endproperty
	a_seed: assert property (p_seed) else $error("seed not taken");

	// Busy only ever follows a byte write
	property p_busy_cause;
		!byte_wr_i |=> !busy_o;
	endproperty
	a_busy_cause: assert property (p_busy_cause) else $error("busy without a byte write");

	// A lone byte gives exactly one busy cycle; a stuck flag would
	// run the step again and corrupt the held remainder
	property p_busy_drops;
		s_lone_byte |=> !busy_o;
	endproperty
	a_busy_drops: assert property (p_busy_drops) else $error("busy held past one step");

	// The input register takes each byte on its write edge
	property p_byte_taken;
		byte_wr_i |=> byte_reg_o == $past(byte_data_i);
	endproperty
	a_byte_taken: assert property (p_byte_taken) else $error("byte not captured");

	// ...and keeps it until the next byte write
	property p_byte_kept;
		!byte_wr_i |=> $stable(byte_reg_o);
	endproperty
	a_byte_kept: assert property (p_byte_kept) else $error("byte register changed");

	// Mode travels with its byte, so a later mode change cannot touch a step
	property p_mode_taken;
		byte_wr_i |=> in_reg.poly == $past(poly_sel_i) &&
			in_reg.lsb_first == $past(lsb_first_i);
	endproperty
	a_mode_taken: assert property (p_mode_taken) else $error("mode not captured");

	property p_mode_kept;
		!byte_wr_i |=> $stable(in_reg.poly) && $stable(in_reg.lsb_first);
	endproperty
	a_mode_kept: assert property (p_mode_kept) else $error("mode changed without a byte");

	// Leaving reset, the outputs show the idle values before any write;
	// a step or seed cannot reach the result before the next edge
	property p_reset_out;
		$rose(arst_n_i) |-> result_o == CCB_RESULT_RST && byte_reg_o == CCB_BYTE_RST &&
			!busy_o;
	endproperty
	a_reset_out: assert property (p_reset_out) else $error("outputs not idle after reset");
endmodule : ccb_engine
`default_nettype wire

// ===== rtl/ccb_pkg.sv
// Package for the byte-serial CRC engine: constants and carrier types
package ccb_pkg;
	localparam int CCB_CRC_W = 16;
	localparam int CCB_BYTE_W = 8;
	// Generator coefficients without the x^16 term
	localparam logic [15:0] CCB_POLY_CRC16 = 16'h8005;
	localparam logic [15:0] CCB_POLY_CCITT = 16'h1021;
	// Values after reset
	localparam logic [15:0] CCB_RESULT_RST = 16'h0000;
	localparam logic [7:0] CCB_BYTE_RST = 8'h00;
	// Cycles from a byte write to an updated result
	localparam int CCB_STEP_CYCLES = 2;

	// Polynomial selection
	typedef enum logic {
		CCB_POLY_SEL_CRC16 = 1'b0,
		CCB_POLY_SEL_CCITT = 1'b1
	} ccb_poly_type;

	// One captured byte with the mode it was written under
	typedef struct packed {
		ccb_poly_type poly;
		logic lsb_first;
		logic [7:0] data;
	} ccb_req_type;
endpackage : ccb_pkg

// ===== rtl/ccb_step.sv
// One byte of CRC division, combinational
`timescale 1ns/10ps
`default_nettype none
module ccb_step (
	input wire ccb_pkg::ccb_req_type req_i,
	input wire logic [15:0] rem_i,
	output logic [15:0] rem_o
);
	import ccb_pkg::*;

	function automatic logic [7:0] rev8(input logic [7:0] v);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++) begin
			r[i] = v[7 - i];
		end
		return r;
	endfunction : rev8

	function automatic logic [15:0] rev16(input logic [15:0] v);
		logic [15:0] r;
		r = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			r[i] = v[15 - i];
		end
		return r;
	endfunction : rev16

	// Byte shifted up 16 plus remainder shifted up 8, reduced bit by bit
	always_comb begin
		logic [15:0] r;
		logic [15:0] poly;
		logic [7:0] b;
		r = req_i.lsb_first ? rev16(rem_i) : rem_i;
		b = req_i.lsb_first ? rev8(req_i.data) : req_i.data;
		poly = (req_i.poly == CCB_POLY_SEL_CCITT) ? CCB_POLY_CCITT : CCB_POLY_CRC16;
		r[15:8] = r[15:8] ^ b;
		for (int i = 0; i < 8; i++) begin
			r = r[15] ? ({r[14:0], 1'b0} ^ poly) : {r[14:0], 1'b0};
		end
		rem_o = req_i.lsb_first ? rev16(r) : r;
	end
endmodule : ccb_step
`default_nettype wire

// ===== dv/ccb_engine_tb.sv
// Self-checking testbench for the byte-serial CRC engine
`timescale 1ns/10ps
`default_nettype none
module ccb_engine_tb;
	import ccb_pkg::*;
	logic core_clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic seed_wr_i = 1'b0;
	logic [15:0] seed_data_i = 16'h0000;
	logic byte_wr_i = 1'b0;
	logic [7:0] byte_data_i = 8'h00;
	ccb_poly_type poly_sel_i = CCB_POLY_SEL_CRC16;
	logic lsb_first_i = 1'b0;
	logic [15:0] result_o;
	logic [7:0] byte_reg_o;
	logic busy_o;
	logic [15:0] last_res = 16'h0000;
	int fail_count = 0;
	int num_checks = 0;
	ccb_engine DUT (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .seed_wr_i(seed_wr_i),
		.seed_data_i(seed_data_i), .byte_wr_i(byte_wr_i), .byte_data_i(byte_data_i),
		.poly_sel_i(poly_sel_i), .lsb_first_i(lsb_first_i), .result_o(result_o),
		.byte_reg_o(byte_reg_o), .busy_o(busy_o));
	// 20 MHz clock
	initial begin
		forever #25 core_clk_i = ~core_clk_i;
	end
	// Four-state compare, so an unknown never passes
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Seed write; the value must show one edge later
	task automatic seed(input logic [15:0] v);
		@(posedge core_clk_i);
		seed_wr_i <= 1'b1;
		seed_data_i <= v;
		@(posedge core_clk_i);
		seed_wr_i <= 1'b0;
		#1 chk(result_o, v);
		last_res = v;
	endtask : seed
	// Byte write; old result must stand one cycle, new one lands the next
	task automatic put(input logic [7:0] d, input ccb_poly_type p, input logic l,
		input logic [15:0] exp);
		@(posedge core_clk_i);
		byte_wr_i <= 1'b1;
		byte_data_i <= d;
		poly_sel_i <= p;
		lsb_first_i <= l;
		@(posedge core_clk_i);
		byte_wr_i <= 1'b0;
		#1 chk(16'(busy_o), 16'h0001);
		chk(16'(byte_reg_o), 16'(d));
		chk(result_o, last_res);
		@(posedge core_clk_i);
		#1 chk(result_o, exp);
		chk(16'(busy_o), 16'h0000);
		last_res = exp;
	endtask : put
	task automatic test_msb_crc16;
		seed(16'h0000);
		put(8'h80, CCB_POLY_SEL_CRC16, 1'b0, 16'h8303);
		put(8'hC4, CCB_POLY_SEL_CRC16, 1'b0, 16'h0292);
		$display("test_msb_crc16 done");
	endtask : test_msb_crc16
	task automatic test_lsb_ccitt;
		seed(16'h0000);
		put(8'h01, CCB_POLY_SEL_CCITT, 1'b1, 16'h1189);
		put(8'h23, CCB_POLY_SEL_CCITT, 1'b1, 16'h0A41);
		$display("test_lsb_ccitt done");
	endtask : test_lsb_ccitt
	// Reseeding mid-stream must discard the held remainder
	task automatic test_reseed;
		seed(16'h8303);
		put(8'hC4, CCB_POLY_SEL_CRC16, 1'b0, 16'h0292);
		seed(16'h0000);
		put(8'h80, CCB_POLY_SEL_CCITT, 1'b0, 16'h9188);
		$display("test_reseed done");
	endtask : test_reseed
	task automatic end_of_test;
		$display("checks=%0d mismatches=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_of_test
	// Main sequence
	initial begin
		repeat (5) @(posedge core_clk_i);
		arst_n_i <= 1'b1;
		#1 chk(result_o, 16'h0000);
		test_msb_crc16();
		test_lsb_ccitt();
		test_reseed();
		end_of_test();
	end
endmodule : ccb_engine_tb
`default_nettype wire
